// >>> include/flash_host_defines.svh
// register map, command codes, status bit positions and bus timing of the flash host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_STATUS 12'h008
`define REG_CFG 12'h00C
`define CMD_READ_STATUS 8'h70
`define CMD_LOCK_SETUP 8'h60
`define CMD_BLOCK_LOCK 8'h01
`define CMD_PERM_LOCK 8'hF1
`define CMD_CONFIRM 8'hD0
`define CMD_CHIP_ERASE 8'h30
`define CMD_READ_ARRAY 8'hFF
`define CMD_CLEAR_STATUS_DEF 8'h50
`define SR_READY 7
`define SR_ERASE_FAIL 5
`define SR_WRITE_FAIL 4
`define SR_SUPPLY_ERR 3
`define SR_PROTECT 1
`define ST_BUSY 8
`define ST_DONE 9
`define ST_ERR 10
`define ST_SEQ_ERR 11
`define ST_REFUSED 12
`define ST_RDY_PIN 13
`define CFG_DEFER 0
`define CFG_RP_HOLD 1
`define CTRL_OP_RESET 3'h0
`define ADDR_RESET 21'h000000
`define FL_ADDR_W 21
`define CLK_PERIOD_NS 25
`define T_WRITE_PULSE_NS 100
`define T_READ_ACCESS_NS 150
`define WR_CYC ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC ((`T_READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> include/flash_host_pkg.sv
// types shared by the flash host sequencer and its pin engine
package flash_host_pkg;
  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_SET_BLOCK = 3'h1,
    OP_SET_PERM = 3'h2,
    OP_CLEAR_LOCKS = 3'h3,
    OP_CHIP_ERASE = 3'h4,
    OP_READ_STATUS = 3'h5,
    OP_CLEAR_STATUS = 3'h6,
    OP_READ_ARRAY = 3'h7
  } op_t;

  typedef enum logic [3:0]
  {
    S_IDLE = 4'h0,
    S_PRE_CMD = 4'h1,
    S_PRE_RD = 4'h2,
    S_SETUP = 4'h3,
    S_CONFIRM = 4'h4,
    S_POST_RD = 4'h5,
    S_RESTORE = 4'h6,
    S_SINGLE = 4'h7,
    S_SINGLE_RD = 4'h8
  } seq_state_t;

  typedef enum logic [1:0]
  {
    E_IDLE = 2'h0,
    E_PULSE = 2'h1,
    E_DONE = 2'h2,
    E_RECOVER = 2'h3
  } pin_state_t;

  // ops that start the internal engine and so need ready first
  function automatic logic is_engine_op(input op_t op);
    is_engine_op = (op == OP_SET_BLOCK) || (op == OP_SET_PERM) || (op == OP_CLEAR_LOCKS) ||
                   (op == OP_CHIP_ERASE);
  endfunction
endpackage

// >>> include/flash_req_if.sv
// one flash bus cycle request between the sequencer and the pin engine
interface flash_req_if;
  logic req;
  logic we;
  logic [20:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output we, output addr, output wdata, input done, input rdata);
  modport eng (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

// >>> logic/flash_pin_engine.sv
// pin engine: turns one request into a single write or read cycle on the flash pins
`include "flash_host_defines.svh"
module flash_pin_engine
(
  input wire logic clk,
  input wire logic rst_n,
  flash_req_if.eng rq,
  output logic [20:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  localparam logic [3:0] WR_CNT = 4'(`WR_CYC - 1);
  localparam logic [3:0] RD_CNT = 4'(`RD_CYC - 1);

  flash_host_pkg::pin_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic we_r, we_nxt;
  logic [20:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic [7:0] dq_s1_r, dq_s2_r, dq_s3_r;

  // data pins only count once the second and third stage agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      dq_s3_r <= 8'h00;
    end
    else
    begin
      dq_s1_r <= fl_dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // cycle sequencing; recover gives one idle cycle so a held req is not retaken
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    unique case (st_r)
      flash_host_pkg::E_IDLE:
      begin
        if (rq.req)
        begin
          st_nxt = flash_host_pkg::E_PULSE;
          we_nxt = rq.we;
          addr_nxt = rq.addr;
          wd_nxt = rq.wdata;
          cnt_nxt = rq.we ? WR_CNT : RD_CNT;
        end
      end
      flash_host_pkg::E_PULSE:
      begin
        if (cnt_r != 4'h0)
          cnt_nxt = cnt_r - 4'h1;
        else if (we_r || (dq_s2_r == dq_s3_r))
        begin
          st_nxt = flash_host_pkg::E_DONE;
          if (!we_r)
            rd_nxt = dq_s3_r;
        end
      end
      flash_host_pkg::E_DONE:
        st_nxt = flash_host_pkg::E_RECOVER;
      flash_host_pkg::E_RECOVER:
        st_nxt = flash_host_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= flash_host_pkg::E_IDLE;
      cnt_r <= 4'h0;
      we_r <= 1'b0;
      addr_r <= `ADDR_RESET;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
    end
  end

  // strobes from state flops; data held one cycle past the write strobe
  assign fl_addr = addr_r;
  assign fl_dq_o = wd_r;
  assign fl_dq_oe = we_r && (st_r == flash_host_pkg::E_PULSE || st_r == flash_host_pkg::E_DONE);
  assign fl_ce_n = !(st_r == flash_host_pkg::E_PULSE);
  assign fl_we_n = !(st_r == flash_host_pkg::E_PULSE && we_r);
  assign fl_oe_n = !(st_r == flash_host_pkg::E_PULSE && !we_r);
  assign rq.done = (st_r == flash_host_pkg::E_DONE);
  assign rq.rdata = rd_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_oe_selected;
    !fl_oe_n |-> !fl_ce_n && !fl_dq_oe;
  endproperty
  a_oe_selected: assert property (p_oe_selected) else $error("read strobe without select");

  property p_write_width;
    $fell(fl_we_n) |-> (!fl_we_n && fl_dq_oe) [*4] ##1 fl_we_n && fl_dq_oe;
  endproperty
  a_write_width: assert property (p_write_width) else $error("write strobe width wrong");
endmodule

// >>> logic/flash_lock_host.sv
// flash lock-bit and status host: APB registers, command sequencer, reset and ready pins
// Operation
// - set lock: write 60H then 01H at block or F1H at device address
// - clear locks: 60H then D0H, then FFH back to array read
// - after 70H reads return the status byte; bit 7 high means ready
// - after an error, clear status before any retry
// - lock sets may chain; error check and FFH may wait till the end
// - select from address decode, output enable only on reads; FL_CE_N here follows the pin engine pulse state
// - reset/power-down pin follows system power ok
//
// Our own choices: the register addresses and the APB register port.
`include "flash_host_defines.svh"
module flash_lock_host
#(
  parameter logic [7:0] CLEAR_STATUS_CMD = `CMD_CLEAR_STATUS_DEF
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [20:0] FL_ADDR,
  output logic [7:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [7:0] FL_DQ_I,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RP_N,
  input wire logic FL_RDY_BUSY_N,
  input wire logic SYS_POWER_OK
);
  logic rst_s1_r, rst_n_s;
  logic [2:0] pok_r, rdy_r;
  logic pok_lvl_r, rdy_lvl_r;

  // reset released through two flops
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_s <= rst_s1_r;
    end
  end

  // pins pass three flops; level moves only when stages two and three agree
  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      pok_r <= 3'h0;
      rdy_r <= 3'h0;
      pok_lvl_r <= 1'b0;
      rdy_lvl_r <= 1'b0;
    end
    else
    begin
      pok_r <= {pok_r[1:0], SYS_POWER_OK};
      rdy_r <= {rdy_r[1:0], FL_RDY_BUSY_N};
      if (pok_r[1] == pok_r[2])
        pok_lvl_r <= pok_r[2];
      if (rdy_r[1] == rdy_r[2])
        rdy_lvl_r <= rdy_r[2];
    end
  end

  flash_req_if rq ();
  flash_pin_engine u_pins
  (
    .clk(CLK),
    .rst_n(rst_n_s),
    .rq(rq),
    .fl_addr(FL_ADDR),
    .fl_dq_o(FL_DQ_O),
    .fl_dq_oe(FL_DQ_OE),
    .fl_dq_i(FL_DQ_I),
    .fl_ce_n(FL_CE_N),
    .fl_oe_n(FL_OE_N),
    .fl_we_n(FL_WE_N)
  );

  flash_host_pkg::seq_state_t st_r, st_nxt;
  flash_host_pkg::op_t op_r, op_nxt;
  logic [20:0] addr_r, addr_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic err_r, err_nxt, done_r, done_nxt, refused_r, refused_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wr_acc, start;
  flash_host_pkg::op_t wr_op;

  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign wr_op = flash_host_pkg::op_t'(PWDATA[2:0]);
  assign start = wr_acc && (PADDR == `REG_CTRL) && (wr_op != flash_host_pkg::OP_NONE);

  // sequencer; device flags are read back, and only the clear status op or a reset on FL_RP_N clears them
  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    cfg_nxt = cfg_r;
    sr_nxt = sr_r;
    err_nxt = err_r;
    done_nxt = done_r;
    refused_nxt = refused_r;
    if (wr_acc && PADDR == `REG_ADDR)
      addr_nxt = PWDATA[20:0];
    if (wr_acc && PADDR == `REG_CFG)
      cfg_nxt = PWDATA[1:0];
    unique case (st_r)
      flash_host_pkg::S_IDLE:
      begin
        if (start)
        begin
          done_nxt = 1'b0;
          op_nxt = wr_op;
          // a pending device error blocks retries until status is cleared
          if (flash_host_pkg::is_engine_op(wr_op) && err_r)
            refused_nxt = 1'b1;
          else
          begin
            refused_nxt = 1'b0;
            st_nxt = flash_host_pkg::is_engine_op(wr_op) ? flash_host_pkg::S_PRE_CMD : flash_host_pkg::S_SINGLE;
          end
        end
      end
      flash_host_pkg::S_PRE_CMD:
        if (rq.done)
          st_nxt = flash_host_pkg::S_PRE_RD;
      flash_host_pkg::S_PRE_RD:
      begin
        if (rq.done)
        begin
          sr_nxt = rq.rdata;
          if (rq.rdata[`SR_READY])
            st_nxt = flash_host_pkg::S_SETUP;
        end
      end
      flash_host_pkg::S_SETUP:
        if (rq.done)
          st_nxt = flash_host_pkg::S_CONFIRM;
      flash_host_pkg::S_CONFIRM:
        if (rq.done)
          st_nxt = flash_host_pkg::S_POST_RD;
      flash_host_pkg::S_POST_RD:
      begin
        // poll until ready; the busy pin alone floats in some modes so the byte decides
        if (rq.done)
        begin
          sr_nxt = rq.rdata;
          if (rq.rdata[`SR_READY])
          begin
            // sticky device bits accumulate; any of them marks an error
            err_nxt = |{rq.rdata[`SR_ERASE_FAIL], rq.rdata[`SR_WRITE_FAIL], rq.rdata[`SR_SUPPLY_ERR],
                        rq.rdata[`SR_PROTECT]};
            if (cfg_r[`CFG_DEFER] && op_r != flash_host_pkg::OP_CLEAR_LOCKS)
            begin
              st_nxt = flash_host_pkg::S_IDLE;
              done_nxt = 1'b1;
            end
            else
              st_nxt = flash_host_pkg::S_RESTORE;
          end
        end
      end
      flash_host_pkg::S_RESTORE:
      begin
        if (rq.done)
        begin
          st_nxt = flash_host_pkg::S_IDLE;
          done_nxt = 1'b1;
        end
      end
      flash_host_pkg::S_SINGLE:
      begin
        if (rq.done)
        begin
          if (op_r == flash_host_pkg::OP_READ_STATUS)
            st_nxt = flash_host_pkg::S_SINGLE_RD;
          else
          begin
            st_nxt = flash_host_pkg::S_IDLE;
            done_nxt = 1'b1;
            if (op_r == flash_host_pkg::OP_CLEAR_STATUS)
              err_nxt = 1'b0;
          end
        end
      end
      flash_host_pkg::S_SINGLE_RD:
      begin
        if (rq.done)
        begin
          sr_nxt = rq.rdata;
          st_nxt = flash_host_pkg::S_IDLE;
          done_nxt = 1'b1;
        end
      end
      default:
        st_nxt = flash_host_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      st_r <= flash_host_pkg::S_IDLE;
      op_r <= flash_host_pkg::OP_NONE;
      addr_r <= `ADDR_RESET;
      cfg_r <= 2'h0;
      sr_r <= 8'h00;
      err_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      cfg_r <= cfg_nxt;
      sr_r <= sr_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // request to the pin engine: command byte and address chosen by state
  always_comb
  begin
    rq.req = (st_r != flash_host_pkg::S_IDLE);
    rq.we = !(st_r == flash_host_pkg::S_PRE_RD || st_r == flash_host_pkg::S_POST_RD ||
              st_r == flash_host_pkg::S_SINGLE_RD);
    rq.addr = `ADDR_RESET;
    rq.wdata = `CMD_READ_STATUS;
    unique case (st_r)
      flash_host_pkg::S_SETUP:
        rq.wdata = (op_r == flash_host_pkg::OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_LOCK_SETUP;
      flash_host_pkg::S_CONFIRM:
      begin
        rq.addr = addr_r;
        unique case (op_r)
          flash_host_pkg::OP_SET_BLOCK: rq.wdata = `CMD_BLOCK_LOCK;
          flash_host_pkg::OP_SET_PERM: rq.wdata = `CMD_PERM_LOCK;
          default: rq.wdata = `CMD_CONFIRM;
        endcase
      end
      flash_host_pkg::S_RESTORE:
        rq.wdata = `CMD_READ_ARRAY;
      flash_host_pkg::S_SINGLE:
        rq.wdata = (op_r == flash_host_pkg::OP_CLEAR_STATUS) ? CLEAR_STATUS_CMD :
                   (op_r == flash_host_pkg::OP_READ_ARRAY) ? `CMD_READ_ARRAY : `CMD_READ_STATUS;
      default:
        rq.wdata = `CMD_READ_STATUS;
    endcase
  end

  // read data latched in the setup phase, so the access phase needs no wait
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (PSEL && !PENABLE)
    begin
      prdata_nxt = 32'h00000000;
      unique case (PADDR)
        `REG_CTRL: prdata_nxt[2:0] = op_r;
        `REG_ADDR: prdata_nxt[20:0] = addr_r;
        `REG_STATUS:
        begin
          prdata_nxt[7:0] = sr_r;
          prdata_nxt[`ST_BUSY] = (st_r != flash_host_pkg::S_IDLE);
          prdata_nxt[`ST_DONE] = done_r;
          prdata_nxt[`ST_ERR] = err_r;
          prdata_nxt[`ST_SEQ_ERR] = sr_r[`SR_ERASE_FAIL] && sr_r[`SR_WRITE_FAIL];
          prdata_nxt[`ST_REFUSED] = refused_r;
          prdata_nxt[`ST_RDY_PIN] = rdy_lvl_r;
        end
        `REG_CFG: prdata_nxt[1:0] = cfg_r;
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(PADDR == `REG_CTRL || PADDR == `REG_ADDR ||
                                        PADDR == `REG_STATUS || PADDR == `REG_CFG);
  // device held in reset while power is not good or software asks for it
  assign FL_RP_N = pok_lvl_r && !cfg_r[`CFG_RP_HOLD];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_s);

  property p_setup_after_ready;
    $rose(st_r == flash_host_pkg::S_SETUP) |-> sr_r[`SR_READY] && $past(st_r) == flash_host_pkg::S_PRE_RD;
  endproperty
  a_setup_after_ready: assert property (p_setup_after_ready) else $error("setup before ready");

  property p_block_confirm;
    st_r == flash_host_pkg::S_CONFIRM && op_r == flash_host_pkg::OP_SET_BLOCK |->
      rq.wdata == `CMD_BLOCK_LOCK && rq.addr == addr_r;
  endproperty
  a_block_confirm: assert property (p_block_confirm) else $error("bad block lock confirm");

  property p_perm_confirm;
    st_r == flash_host_pkg::S_CONFIRM && op_r == flash_host_pkg::OP_SET_PERM |-> rq.wdata == `CMD_PERM_LOCK;
  endproperty
  a_perm_confirm: assert property (p_perm_confirm) else $error("bad permanent lock confirm");

  property p_clear_flow;
    st_r == flash_host_pkg::S_POST_RD && op_r == flash_host_pkg::OP_CLEAR_LOCKS && rq.done &&
      rq.rdata[`SR_READY] |=> st_r == flash_host_pkg::S_RESTORE && rq.wdata == `CMD_READ_ARRAY;
  endproperty
  a_clear_flow: assert property (p_clear_flow) else $error("no array read after clear");

  property p_poll_cmd;
    st_r == flash_host_pkg::S_PRE_CMD |-> rq.we && rq.wdata == `CMD_READ_STATUS;
  endproperty
  a_poll_cmd: assert property (p_poll_cmd) else $error("poll without status command");

  property p_refuse;
    start && err_r && flash_host_pkg::is_engine_op(wr_op) && st_r == flash_host_pkg::S_IDLE |=>
      st_r == flash_host_pkg::S_IDLE && refused_r;
  endproperty
  a_refuse: assert property (p_refuse) else $error("retry taken with error pending");

  property p_defer;
    st_r == flash_host_pkg::S_POST_RD && rq.done && rq.rdata[`SR_READY] && cfg_r[`CFG_DEFER] &&
      op_r == flash_host_pkg::OP_SET_BLOCK |=> st_r == flash_host_pkg::S_IDLE && done_r;
  endproperty
  a_defer: assert property (p_defer) else $error("deferred set not ended");

  property p_sticky_err;
    err_r && !(st_r == flash_host_pkg::S_SINGLE && op_r == flash_host_pkg::OP_CLEAR_STATUS) &&
      st_r != flash_host_pkg::S_POST_RD |=> err_r;
  endproperty
  a_sticky_err: assert property (p_sticky_err) else $error("error dropped without clear");

  property p_rp_follow;
    !pok_lvl_r |-> !FL_RP_N;
  endproperty
  a_rp_follow: assert property (p_rp_follow) else $error("device out of reset without power");

  c_set_block: cover property (st_r == flash_host_pkg::S_CONFIRM && op_r == flash_host_pkg::OP_SET_BLOCK);
  c_clear_locks: cover property (st_r == flash_host_pkg::S_RESTORE && op_r == flash_host_pkg::OP_CLEAR_LOCKS);
  c_refused: cover property ($rose(refused_r));
  c_busy_poll: cover property (st_r == flash_host_pkg::S_POST_RD && rq.done && !rq.rdata[`SR_READY]);
endmodule

// >>> sim/flash_device_model.sv
// behavioural flash device: command decoder, status byte, engine timer, ready/busy pin
module flash_device_model
#(
  parameter int BUSY_CYC = 40
)
(
  input wire logic clk,
  input wire logic rp_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [20:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_drv,
  output logic rb_low,
  input wire logic perm,
  input wire logic fail,
  input wire logic sup,
  output logic [20:0] cfm_addr,
  output logic [7:0] cfm_data,
  output int ff_cnt,
  output int viol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr, cmd, fl;
  logic [20:0] a;
  logic armed, stat_mode;
  logic [1:0] pend;
  int busy;
  // flags per op; a bad confirm wins over the other causes
  function automatic logic [7:0] flags(input logic [1:0] p, input logic [7:0] c);
    logic wr_op;
    wr_op = (p == 2'h1) && (c == 8'h01 || c == 8'hF1);
    if (!wr_op && c != 8'hD0)
      flags = 8'h30;
    else if (perm)
      flags = 8'h02;
    else if (sup)
      flags = wr_op ? 8'h18 : 8'h28;
    else if (fail)
      flags = wr_op ? 8'h10 : 8'h20;
    else
      flags = 8'h00;
  endfunction
  initial
  begin
    ff_cnt = 0;
    viol = 0;
  end
  // drive only while selected and output enabled
  assign dq_drv = !ce_n && !oe_n;
  assign dq_out = stat_mode ? sr : 8'hAA;
  // low while the engine runs, floats in reset mode
  assign rb_low = rp_n && (busy != 0);
  // commands latch on the trailing edge of the write strobe
  always @(posedge clk or negedge rp_n)
  begin
    if (!rp_n)
    begin
      sr <= 8'h80;
      stat_mode <= 1'b0;
      pend <= 2'h0;
      busy <= 0;
      armed <= 1'b0;
    end
    else
    begin
      if (!ce_n && !oe_n && !we_n)
        viol <= viol + 1;
      if (!ce_n && !we_n)
      begin
        cmd <= dq_in;
        a <= addr;
        armed <= 1'b1;
      end
      else if (armed)
      begin
        armed <= 1'b0;
        // a new engine sequence while busy is a host fault
        if (busy != 0 && (cmd == 8'h60 || cmd == 8'h30))
          viol <= viol + 1;
        if (pend != 2'h0)
        begin
          pend <= 2'h0;
          stat_mode <= 1'b1;
          busy <= BUSY_CYC;
          sr[7] <= 1'b0;
          cfm_addr <= a;
          cfm_data <= cmd;
          fl <= flags(pend, cmd);
        end
        else if (cmd == 8'h60)
          pend <= 2'h1;
        else if (cmd == 8'h30)
          pend <= 2'h2;
        else if (cmd == 8'h70)
          stat_mode <= 1'b1;
        else if (cmd == 8'h50)
          sr <= sr & 8'h80;
        else if (cmd == 8'hFF)
        begin
          stat_mode <= 1'b0;
          ff_cnt <= ff_cnt + 1;
        end
      end
      // flags pile up until cleared
      if (busy == 1)
        sr <= sr | 8'h80 | fl;
      if (busy != 0)
        busy <= busy - 1;
    end
  end
endmodule

// >>> sim/flash_lock_host_tb.sv
// self-checking bench for the flash lock host against a behavioural device
module flash_lock_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] op; logic [2:0] cnd; logic [7:0] sb; logic [7:0] cd;} ent_t;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N;
  logic FL_RP_N, FL_RDY_BUSY_N, SYS_POWER_OK, m_drv, m_rb, perm, fail, sup, rb_seen;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [20:0] FL_ADDR, cfm_addr;
  logic [7:0] FL_DQ_O, FL_DQ_I, m_dq, cfm_data;
  logic [7:0] pat = 8'h00;
  int ff_cnt, viol;
  int n_errors = 0;
  int compares = 0;
  // cond bits are supply, fail, protect
  ent_t tbl [11] = '{'{3'h1, 3'h0, 8'h80, 8'h01}, '{3'h2, 3'h0, 8'h80, 8'hF1}, '{3'h1, 3'h1, 8'h82, 8'h01},
    '{3'h1, 3'h2, 8'h90, 8'h01}, '{3'h1, 3'h4, 8'h98, 8'h01}, '{3'h3, 3'h0, 8'h80, 8'hD0},
    '{3'h3, 3'h1, 8'h82, 8'hD0}, '{3'h3, 3'h2, 8'hA0, 8'hD0}, '{3'h4, 3'h1, 8'h82, 8'hD0},
    '{3'h4, 3'h2, 8'hA0, 8'hD0}, '{3'h4, 3'h4, 8'hA8, 8'hD0}};
  // a released bus changes every cycle, so a stale value never passes
  always @(posedge CLK)
    pat <= pat + 8'h5B;
  assign FL_DQ_I = m_drv ? m_dq : (FL_DQ_OE ? FL_DQ_O : pat);
  assign FL_RDY_BUSY_N = m_rb ? 1'b0 : 1'b1;
  flash_lock_host flash_lock_host_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(FL_DQ_I), .FL_CE_N(FL_CE_N),
    .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_RP_N(FL_RP_N), .FL_RDY_BUSY_N(FL_RDY_BUSY_N),
    .SYS_POWER_OK(SYS_POWER_OK));
  flash_device_model flash_device_model_inst (.clk(CLK), .rp_n(FL_RP_N), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
    .we_n(FL_WE_N), .addr(FL_ADDR), .dq_in(FL_DQ_O), .dq_out(m_dq), .dq_drv(m_drv), .rb_low(m_rb),
    .perm(perm), .fail(fail), .sup(sup), .cfm_addr(cfm_addr), .cfm_data(cfm_data), .ff_cnt(ff_cnt),
    .viol(viol));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
      @(posedge CLK);
    while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge, so a following call never drives psel twice in a step
    @(posedge CLK);
  endtask
  // start an op and poll until done; fst is the first status seen
  task automatic run(input logic [2:0] op, output logic [31:0] fst, output logic [31:0] st);
    logic e;
    apb(1'b1, 12'h000, {29'h0, op}, st, e);
    apb(1'b0, 12'h008, 32'h0, fst, e);
    st = fst;
    for (int i = 0; i < 3000 && st[9] !== 1'b1; i++)
    begin
      apb(1'b0, 12'h008, 32'h0, st, e);
      // the synced ready pin must show busy at least once while the engine runs
      if (st[13] === 1'b0)
        rb_seen = 1'b1;
    end
    check("op done", st[9], 1'b1);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h000, 32'h0, q, e);
    check("ctrl reset", q, 32'h0);
    apb(1'b0, 12'h004, 32'h0, q, e);
    check("addr reset", q, 32'h0);
    apb(1'b0, 12'h008, 32'h0, q, e);
    check("status flags", q[13:8], 6'h20);
    check("rp pin", FL_RP_N, 1'b1);
    apb(1'b0, 12'h010, 32'h0, q, e);
    check("unmapped", e, 1'b1);
  endtask
  task automatic t_ops;
    logic [31:0] st, fst, q;
    logic e;
    int ff0;
    foreach (tbl[i])
    begin
      {sup, fail, perm} <= tbl[i].cnd;
      apb(1'b1, 12'h004, 32'h12345 + i, q, e);
      ff0 = ff_cnt;
      rb_seen = 1'b0;
      run(tbl[i].op, fst, st);
      check("busy", fst[8], 1'b1);
      check("byte", st[7:0], tbl[i].sb);
      check("err", st[10], |tbl[i].sb[5:1]);
      check("seq err", st[11], tbl[i].sb[5] & tbl[i].sb[4]);
      check("confirm", cfm_data, tbl[i].cd);
      if (tbl[i].op != 3'h3)
        check("cfm addr", cfm_addr, 32'h12345 + i);
      check("rdy pin", rb_seen, 1'b1);
      check("restore", ff_cnt - ff0, 1);
      run(3'h6, fst, st);
      check("err clear", st[10], 1'b0);
    end
  endtask
  task automatic t_sticky;
    logic [31:0] st, fst, q;
    logic e;
    int ff0;
    // lock sets chained under defer; no restore until the end
    {sup, fail, perm} <= 3'b000;
    apb(1'b1, 12'h00C, 32'h1, q, e);
    ff0 = ff_cnt;
    run(3'h1, fst, st);
    check("chain first", st[10:8], 3'h2);
    run(3'h2, fst, st);
    {sup, fail, perm} <= 3'b010;
    run(3'h4, fst, st);
    check("deferred", ff_cnt - ff0, 0);
    fail <= 1'b0;
    apb(1'b1, 12'h000, 32'h1, q, e);
    apb(1'b0, 12'h008, 32'h0, st, e);
    check("refused", st[12], 1'b1);
    run(3'h5, fst, st);
    check("sticky", st[7:0], 8'hA0);
    run(3'h6, fst, st);
    run(3'h5, fst, st);
    check("cleared", st[7:0], 8'h80);
    ff0 = ff_cnt;
    run(3'h7, fst, st);
    check("array read", ff_cnt - ff0, 1);
    apb(1'b1, 12'h00C, 32'h0, q, e);
  endtask
  task automatic t_rp;
    logic [31:0] st, fst, q;
    logic e;
    fail <= 1'b1;
    run(3'h4, fst, st);
    fail <= 1'b0;
    apb(1'b1, 12'h00C, 32'h2, q, e);
    repeat (6) @(posedge CLK);
    check("rp hold", FL_RP_N, 1'b0);
    apb(1'b1, 12'h00C, 32'h0, q, e);
    repeat (8) @(posedge CLK);
    run(3'h5, fst, st);
    check("rp clears", st[7:0], 8'h80);
    run(3'h6, fst, st);
    SYS_POWER_OK <= 1'b0;
    repeat (8) @(posedge CLK);
    check("power off", FL_RP_N, 1'b0);
    SYS_POWER_OK <= 1'b1;
    repeat (10) @(posedge CLK);
    check("power on", FL_RP_N, 1'b1);
  endtask
  initial
  begin
    CLK = 1'b0;
    forever
      #12.5 CLK = ~CLK;
  end
  initial
  begin
    #2000000;
    n_errors++;
    summarize();
  end
  initial
  begin
    {RST_N, PSEL, PENABLE, PWRITE, perm, fail, sup, rb_seen} = 8'h00;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    SYS_POWER_OK = 1'b1;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (10) @(posedge CLK);
    t_reset();
    t_ops();
    t_sticky();
    t_rp();
    check("host faults", viol, 0);
    summarize();
  end
endmodule
